// ---- common/pcchr_pkg.sv ----
// Constants and carriers for the paged configuration, calibration and histogram register bank.
// Assumes one clock domain and an 8-bit register port driven by a host interface core.
package pcchr_pkg;
  localparam logic [7:0] PCCHR_APP_MAIN        = 8'h03;
  localparam logic [7:0] PCCHR_PAGE_MASK_A     = 8'h17;
  localparam logic [7:0] PCCHR_PAGE_MASK_B     = 8'h18;
  localparam logic [7:0] PCCHR_PAGE_CALIB      = 8'h19;
  localparam logic [7:0] PCCHR_PAGE_HIST       = 8'h81;
  localparam logic [7:0] PCCHR_CALIB_FIRST     = 8'h24;
  localparam logic [7:0] PCCHR_CALIB_RESULT    = 8'hDC;
  localparam logic [7:0] PCCHR_CALIB_LAST      = 8'hDF;
  localparam logic [7:0] PCCHR_HIST_INDEX      = 8'h24;
  localparam logic [7:0] PCCHR_HIST_LENGTH     = 8'h25;
  localparam logic [7:0] PCCHR_HIST_TSLOT      = 8'h26;
  localparam logic [7:0] PCCHR_HIST_HEAD       = 8'h27;
  localparam logic [7:0] PCCHR_HIST_TAIL       = 8'hA6;
  localparam logic [7:0] PCCHR_MASK_HDISP      = 8'h8D;
  localparam logic [7:0] PCCHR_MASK_VDISP      = 8'h8E;
  localparam logic [7:0] PCCHR_MASK_WIDTH      = 8'h8F;
  localparam logic [7:0] PCCHR_MASK_HEIGHT     = 8'h90;
  localparam logic [7:0] PCCHR_RST_ZERO        = 8'h00;
  localparam logic [7:0] PCCHR_RST_HIST_LENGTH = 8'h80;
  localparam logic [7:0] PCCHR_RESULT_OK       = 8'h00;
  localparam int         PCCHR_TSLOT_BIT       = 0;
  localparam int         PCCHR_CALIB_BYTES     = 188;
  localparam int         PCCHR_HIST_BYTES      = 128;
  localparam int         PCCHR_MASK_SETS       = 2;

  typedef enum logic [1:0] {PCCHR_SEL_NONE, PCCHR_SEL_MASK, PCCHR_SEL_CALIB, PCCHR_SEL_HIST}
    pcchr_sel_e;

  // Host register access: one cycle strobe with address and data
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcchr_req_s;

  // Mask geometry handed to the sensing array, displacements in half elements plus decoded whole part and half flag
  typedef struct packed {
    logic signed [7:0] hdisp_q1;
    logic signed [7:0] vdisp_q1;
    logic signed [6:0] hdisp_whole;
    logic signed [6:0] vdisp_whole;
    logic              hdisp_half;
    logic              vdisp_half;
    logic [7:0]        width;
    logic [7:0]        height;
  } pcchr_geom_s;
endpackage : pcchr_pkg

// ---- core/pcchr_q1_decode.sv ----
// Splits a signed half-element displacement into whole part and half flag.
// Assumes the input is already registered; output is registered too.
module pcchr_q1_decode
  import pcchr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Displacement in half elements
  input  wire logic signed [7:0] q1_val,
  // Decoded displacement
  output logic signed [6:0]      whole_r,
  output logic                   half_r
);
  typedef struct packed {
    logic signed [6:0] whole;
    logic              half;
  } pcchr_q1_s;

  pcchr_q1_s st_r;
  pcchr_q1_s st_nxt;

  always_comb
  begin
    st_nxt       = st_r;
    // Arithmetic shift keeps the sign; half flag is the dropped fraction bit
    st_nxt.whole = q1_val[7:1];
    st_nxt.half  = q1_val[0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign whole_r = st_r.whole;
  assign half_r  = st_r.half;
endmodule // pcchr_q1_decode

// ---- core/pcchr_regs.sv ----
// Paged register bank: mask geometry, factory calibration block, raw histogram subpackets.
// Assumes a host interface core delivers one-cycle read/write strobes synchronous to clk,
// and that firmware supplies app/page selection, the status code and histogram bytes.
//
// How it works
// [RQ1] The horizontal displacement is a signed value stored at twice the real offset.
// [RQ2] The vertical displacement uses the same doubled signed encoding.
// [RQ3] The host keeps width and height within their valid whole-element ranges; both reset to 0.
// [RQ4] The calibration page is visible only with the main app on and the calibration page chosen.
// [RQ5] The calibration block is a contiguous read-write byte range, all reset to zero.
// [RQ6] One byte of the calibration block mirrors the status code, zero meaning success.
// [RQ7] Histogram subpacket registers are visible only on the histogram page of the main app.
// [RQ8] The payload length reads as 128, also its reset value.
// [RQ9] Bit 0 of the subpacket config selects the first or second timeslot.
// [RQ10] The 128 payload bytes sit at consecutive offsets from head to tail.
// [RQ11] Mask geometry is visible only on one of the two mask pages of the main app.
// [RQ12] The same offset decodes to different storage depending on the selected page.
module pcchr_regs
  import pcchr_pkg::*;
#(
  parameter int CALIB_BYTES = PCCHR_CALIB_BYTES,
  parameter int HIST_BYTES  = PCCHR_HIST_BYTES
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset_n,
  // Page selection from the application
  input  wire logic [7:0]      app_id,
  input  wire logic [7:0]      page_id,
  // Host register port
  input  wire pcchr_pkg::pcchr_req_s req,
  output logic [7:0]           rdata_r,
  output logic                 rvalid_r,
  // Firmware side
  input  wire logic [7:0]      calib_result_code,
  input  wire logic            calib_active,
  input  wire logic            hist_load,
  input  wire logic [6:0]      hist_load_idx,
  input  wire logic [7:0]      hist_load_data,
  // Decoded outputs
  output pcchr_pkg::pcchr_geom_s geom_r,
  output logic                 calib_failed_r,
  output logic [7:0]           hist_index_r,
  output logic                 hist_second_slot_r
);
  typedef struct packed {
    logic [PCCHR_MASK_SETS-1:0][7:0] hdisp;
    logic [PCCHR_MASK_SETS-1:0][7:0] vdisp;
    logic [PCCHR_MASK_SETS-1:0][7:0] width;
    logic [PCCHR_MASK_SETS-1:0][7:0] height;
    logic [CALIB_BYTES-1:0][7:0]     calib;
    logic [7:0]                      hidx;
    logic [7:0]                      hlen;
    logic [7:0]                      hcfg;
    logic [HIST_BYTES-1:0][7:0]      hdata;
    logic [7:0]                      rdata;
    logic                            rvalid;
    logic                            cfail;
  } pcchr_state_s;

  pcchr_state_s st_r;
  pcchr_state_s st_nxt;
  pcchr_sel_e   sel;
  logic         mset;
  logic [7:0]   cidx;
  logic [7:0]   hoff;
  logic signed [6:0] hw_w;
  logic signed [6:0] vw_w;
  logic         hh_w;
  logic         vh_w;

  // Page decode shared by reads and writes
  function automatic pcchr_sel_e page_sel(input logic [7:0] app, input logic [7:0] pg);
    if (app != PCCHR_APP_MAIN)
      return PCCHR_SEL_NONE;
    else if (pg == PCCHR_PAGE_MASK_A || pg == PCCHR_PAGE_MASK_B)
      return PCCHR_SEL_MASK; // [RQ11]
    else if (pg == PCCHR_PAGE_CALIB)
      return PCCHR_SEL_CALIB; // [RQ4]
    else if (pg == PCCHR_PAGE_HIST)
      return PCCHR_SEL_HIST; // [RQ7]
    else
      return PCCHR_SEL_NONE;
  endfunction

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  always_comb
  begin
    sel  = page_sel(app_id, page_id);
    mset = (page_id == PCCHR_PAGE_MASK_B);
    cidx = req.addr - PCCHR_CALIB_FIRST;
    hoff = req.addr - PCCHR_HIST_HEAD;
  end

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = req.rd;
    st_nxt.rdata  = 8'h00;
    // Reads: storage chosen by page first, then by offset
    if (req.rd)
    begin
      case (sel) // [RQ12]
        PCCHR_SEL_MASK:
        begin
          case (req.addr)
            PCCHR_MASK_HDISP:  st_nxt.rdata = st_r.hdisp[mset];
            PCCHR_MASK_VDISP:  st_nxt.rdata = st_r.vdisp[mset];
            PCCHR_MASK_WIDTH:  st_nxt.rdata = st_r.width[mset];
            PCCHR_MASK_HEIGHT: st_nxt.rdata = st_r.height[mset];
            default:           st_nxt.rdata = 8'h00;
          endcase
        end
        PCCHR_SEL_CALIB:
        begin
          if (in_range(req.addr, PCCHR_CALIB_FIRST, PCCHR_CALIB_LAST))
            st_nxt.rdata = st_r.calib[cidx]; // [RQ5]
        end
        PCCHR_SEL_HIST:
        begin
          if (req.addr == PCCHR_HIST_INDEX)
            st_nxt.rdata = st_r.hidx;
          else if (req.addr == PCCHR_HIST_LENGTH)
            st_nxt.rdata = st_r.hlen; // [RQ8]
          else if (req.addr == PCCHR_HIST_TSLOT)
            st_nxt.rdata = st_r.hcfg;
          else if (in_range(req.addr, PCCHR_HIST_HEAD, PCCHR_HIST_TAIL))
            st_nxt.rdata = st_r.hdata[hoff[6:0]]; // [RQ10]
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Writes: ignored when no page of this bank is open
    if (req.wr)
    begin
      case (sel)
        PCCHR_SEL_MASK:
        begin
          case (req.addr)
            PCCHR_MASK_HDISP:  st_nxt.hdisp[mset]  = req.wdata; // [RQ1]
            PCCHR_MASK_VDISP:  st_nxt.vdisp[mset]  = req.wdata; // [RQ2]
            PCCHR_MASK_WIDTH:  st_nxt.width[mset]  = req.wdata; // [RQ3]
            PCCHR_MASK_HEIGHT: st_nxt.height[mset] = req.wdata; // [RQ3]
            default:           st_nxt.width        = st_r.width;
          endcase
        end
        PCCHR_SEL_CALIB:
        begin
          if (in_range(req.addr, PCCHR_CALIB_FIRST, PCCHR_CALIB_LAST))
            st_nxt.calib[cidx] = req.wdata; // [RQ5]
        end
        PCCHR_SEL_HIST:
        begin
          if (req.addr == PCCHR_HIST_INDEX)
            st_nxt.hidx = req.wdata;
          else if (req.addr == PCCHR_HIST_TSLOT)
            st_nxt.hcfg = {7'h00, req.wdata[PCCHR_TSLOT_BIT]}; // [RQ9]
          else if (in_range(req.addr, PCCHR_HIST_HEAD, PCCHR_HIST_TAIL))
            st_nxt.hdata[hoff[6:0]] = req.wdata; // [RQ10]
        end
        default: st_nxt.hidx = st_r.hidx;
      endcase
    end
    // Length is fixed; host writes cannot move it
    st_nxt.hlen = PCCHR_RST_HIST_LENGTH; // [RQ8]
    // Firmware histogram fill wins over a host write to the same byte
    if (hist_load)
      st_nxt.hdata[hist_load_idx] = hist_load_data; // [RQ10]
    // Status mirror follows the live code while calibration runs
    if (calib_active)
    begin
      st_nxt.calib[PCCHR_CALIB_RESULT - PCCHR_CALIB_FIRST] = calib_result_code; // [RQ6]
      st_nxt.cfail = (calib_result_code != PCCHR_RESULT_OK); // [RQ6]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r      <= '0; // [RQ3] [RQ5]
      st_r.hlen <= PCCHR_RST_HIST_LENGTH; // [RQ8]
    end
    else
      st_r <= st_nxt;
  end

  // Active geometry set follows page_id alone: second set on mask page B, whatever the app; first set otherwise
  pcchr_q1_decode u_hdec (
    .clk     (clk),
    .reset_n (reset_n),
    .q1_val  (st_r.hdisp[mset]),
    .whole_r (hw_w),
    .half_r  (hh_w)
  ); // [RQ1]

  pcchr_q1_decode u_vdec (
    .clk     (clk),
    .reset_n (reset_n),
    .q1_val  (st_r.vdisp[mset]),
    .whole_r (vw_w),
    .half_r  (vh_w)
  ); // [RQ2]

  typedef struct packed {
    pcchr_geom_s geom;
  } pcchr_out_s;

  pcchr_out_s out_r;
  pcchr_out_s out_nxt;

  always_comb
  begin
    out_nxt                    = out_r;
    out_nxt.geom.hdisp_q1      = st_r.hdisp[mset];
    out_nxt.geom.vdisp_q1      = st_r.vdisp[mset];
    out_nxt.geom.hdisp_whole   = hw_w;
    out_nxt.geom.vdisp_whole   = vw_w;
    out_nxt.geom.hdisp_half    = hh_w;
    out_nxt.geom.vdisp_half    = vh_w;
    out_nxt.geom.width         = st_r.width[mset];
    out_nxt.geom.height        = st_r.height[mset];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      out_r <= '0;
    else
      out_r <= out_nxt;
  end

  assign geom_r             = out_r.geom;
  assign rdata_r            = st_r.rdata;
  assign rvalid_r           = st_r.rvalid;
  assign calib_failed_r     = st_r.cfail;
  assign hist_index_r       = st_r.hidx;
  assign hist_second_slot_r = st_r.hcfg[PCCHR_TSLOT_BIT]; // [RQ9]
endmodule // pcchr_regs

// ---- sim/pcchr_host_model.sv ----
// Host model issuing byte reads and writes on the register port.
// Assumes requests launch at the falling edge and answers come one cycle on.
module pcchr_host_model
  import pcchr_pkg::*;
(
  // Clock
  input  wire logic            clk,
  // Register port
  output pcchr_pkg::pcchr_req_s req,
  input  wire logic [7:0]      rdata_r,
  input  wire logic            rvalid_r
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Released address and data are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    v = rvalid_r;
    d = rdata_r;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule // pcchr_host_model

// ---- sim/pcchr_regs_bench.sv ----
// Bench for the paged register bank with the host model on its register port.
// Assumes a 100 ns clock and firmware inputs driven here at the falling edge.
module pcchr_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcchr_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  app_id = PCCHR_APP_MAIN;
  logic [7:0]  page_id = PCCHR_PAGE_HIST;
  logic [7:0]  code = 8'h00;
  logic        cal_on = 1'b0;
  logic        ld = 1'b0;
  logic [6:0]  ld_idx = 7'h00;
  logic [7:0]  ld_data = 8'h00;
  pcchr_req_s  req;
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  pcchr_geom_s geom_r;
  logic        calib_failed_r;
  logic [7:0]  hist_index_r;
  logic        hist_second_slot_r;
  int          num_errors = 0;
  int          n_checks = 0;

  always #50 clk = ~clk;

  pcchr_regs u_dut (.clk, .reset_n, .app_id, .page_id, .req, .rdata_r, .rvalid_r,
    .calib_result_code(code), .calib_active(cal_on), .hist_load(ld), .hist_load_idx(ld_idx),
    .hist_load_data(ld_data), .geom_r, .calib_failed_r, .hist_index_r, .hist_second_slot_r);
  pcchr_host_model u_host (.clk, .req, .rdata_r, .rvalid_r);

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    check({nm, " valid"}, {7'h00, v}, 8'h01);
    check(nm, d, exp);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset_vals();
    rchk("length", PCCHR_HIST_LENGTH, PCCHR_RST_HIST_LENGTH);
    rchk("tail", PCCHR_HIST_TAIL, PCCHR_RST_ZERO);
    page_id = PCCHR_PAGE_MASK_A;
    rchk("width", PCCHR_MASK_WIDTH, PCCHR_RST_ZERO);
    page_id = PCCHR_PAGE_CALIB;
    rchk("calib last", PCCHR_CALIB_LAST, PCCHR_RST_ZERO);
  endtask
  task automatic t_mask();
    page_id = PCCHR_PAGE_MASK_A;
    u_host.wr(PCCHR_MASK_HDISP, 8'hFB);
    u_host.wr(PCCHR_MASK_VDISP, 8'h05);
    u_host.wr(PCCHR_MASK_WIDTH, 8'h12);
    u_host.wr(PCCHR_MASK_HEIGHT, 8'h0A);
    repeat (3) @(negedge clk);
    check("hwhole", {1'b0, geom_r.hdisp_whole}, 8'h7D);
    check("hhalf", {7'h00, geom_r.hdisp_half}, 8'h01);
    check("vwhole", {1'b0, geom_r.vdisp_whole}, 8'h02);
    check("vhalf", {7'h00, geom_r.vdisp_half}, 8'h01);
    check("geom height", geom_r.height, 8'h0A);
    check("geom width", geom_r.width, 8'h12);
    check("hq1", geom_r.hdisp_q1, 8'hFB);
    check("vq1", geom_r.vdisp_q1, 8'h05);
    page_id = PCCHR_PAGE_MASK_B;
    rchk("set b", PCCHR_MASK_HDISP, PCCHR_RST_ZERO);
    check("set b hq1", geom_r.hdisp_q1, PCCHR_RST_ZERO);
    check("set b width", geom_r.width, PCCHR_RST_ZERO);
  endtask
  task automatic t_calib();
    page_id = PCCHR_PAGE_CALIB;
    u_host.wr(PCCHR_CALIB_FIRST, 8'h11);
    u_host.wr(PCCHR_MASK_HDISP, 8'h33);
    rchk("calib first", PCCHR_CALIB_FIRST, 8'h11);
    rchk("calib mid", PCCHR_MASK_HDISP, 8'h33);
    page_id = PCCHR_PAGE_MASK_A;
    rchk("mask hdisp", PCCHR_MASK_HDISP, 8'hFB);
    page_id = PCCHR_PAGE_CALIB;
    code = 8'h07;
    cal_on = 1'b1;
    repeat (3) @(negedge clk);
    check("failed", {7'h00, calib_failed_r}, 8'h01);
    rchk("result", PCCHR_CALIB_RESULT, 8'h07);
    code = PCCHR_RESULT_OK;
    repeat (3) @(negedge clk);
    cal_on = 1'b0;
    check("ok", {7'h00, calib_failed_r}, 8'h00);
    app_id = 8'h80;
    rchk("app off", PCCHR_CALIB_FIRST, PCCHR_RST_ZERO);
    app_id = PCCHR_APP_MAIN;
  endtask
  task automatic t_hist();
    page_id = PCCHR_PAGE_HIST;
    u_host.wr(PCCHR_HIST_TSLOT, 8'hFF);
    u_host.wr(PCCHR_HIST_LENGTH, 8'h00);
    u_host.wr(PCCHR_HIST_INDEX, 8'h05);
    rchk("tslot", PCCHR_HIST_TSLOT, 8'h01);
    check("slot out", {7'h00, hist_second_slot_r}, 8'h01);
    rchk("len", PCCHR_HIST_LENGTH, PCCHR_RST_HIST_LENGTH);
    check("index", hist_index_r, 8'h05);
    ld = 1'b1;
    ld_data = 8'hA1;
    @(negedge clk);
    ld_idx = 7'h7F;
    ld_data = 8'h7E;
    @(negedge clk);
    ld = 1'b0;
    rchk("head", PCCHR_HIST_HEAD, 8'hA1);
    rchk("tail", PCCHR_HIST_TAIL, 8'h7E);
    u_host.wr(PCCHR_HIST_TSLOT, 8'h00);
    rchk("tslot 0", PCCHR_HIST_TSLOT, 8'h00);
    page_id = 8'h42;
    rchk("page off", PCCHR_HIST_INDEX, PCCHR_RST_ZERO);
  endtask

  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_reset_vals();
    t_mask();
    t_calib();
    t_hist();
    wrap_up();
  end
  initial
  begin
    #2ms;
    num_errors++;
    wrap_up();
  end
endmodule // pcchr_regs_bench

// ---- sim/pcchr_regs_checker.sv ----
// Port checker for the paged register bank.
// Assumes one clock domain and a one-cycle read answer.
module pcchr_regs_checker
  import pcchr_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   reset_n,
  // Selection and host port
  input wire logic [7:0]             app_id,
  input wire logic [7:0]             page_id,
  input wire pcchr_pkg::pcchr_req_s  req,
  input wire logic [7:0]             rdata_r,
  input wire logic                   rvalid_r,
  // Firmware side and decoded outputs
  input wire logic [7:0]             calib_result_code,
  input wire logic                   calib_active,
  input wire pcchr_pkg::pcchr_geom_s geom_r,
  input wire logic                   calib_failed_r,
  input wire logic                   hist_second_slot_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic on_hist;
  logic page_ok;
  assign on_hist = (app_id == PCCHR_APP_MAIN) && (page_id == PCCHR_PAGE_HIST);
  assign page_ok = page_id inside {PCCHR_PAGE_MASK_A, PCCHR_PAGE_MASK_B,
                                   PCCHR_PAGE_CALIB, PCCHR_PAGE_HIST};
  a_read_answer: assert property (req.rd |=> rvalid_r)
    else $error("read without answer");
  a_idle_quiet: assert property (!req.rd |=> !rvalid_r && rdata_r == 8'h00)
    else $error("read data outside an answer");
  a_length_fixed: assert property (
    req.rd && on_hist && req.addr == PCCHR_HIST_LENGTH |=> rdata_r == PCCHR_RST_HIST_LENGTH)
    else $error("payload length wrong");
  a_app_closed: assert property (
    req.rd && app_id != PCCHR_APP_MAIN |=> rdata_r == 8'h00)
    else $error("data read with app off");
  a_page_closed: assert property (req.rd && !page_ok |=> rdata_r == 8'h00)
    else $error("data read on closed page");
  a_tslot_bit: assert property (
    req.wr && on_hist && req.addr == PCCHR_HIST_TSLOT
      |=> hist_second_slot_r == $past(req.wdata[PCCHR_TSLOT_BIT]))
    else $error("timeslot bit wrong");
  a_hdisp_split: assert property (
    geom_r.hdisp_whole == $past(geom_r.hdisp_q1[7:1])
      && geom_r.hdisp_half == $past(geom_r.hdisp_q1[0]))
    else $error("horizontal split wrong");
  a_vdisp_split: assert property (
    geom_r.vdisp_whole == $past(geom_r.vdisp_q1[7:1])
      && geom_r.vdisp_half == $past(geom_r.vdisp_q1[0]))
    else $error("vertical split wrong");
  a_calib_flag: assert property (
    calib_active ##1 (calib_active && $stable(calib_result_code))
      |=> calib_failed_r == ($past(calib_result_code) != PCCHR_RESULT_OK))
    else $error("calibration flag wrong");
  c_hist_read: cover property (req.rd && on_hist);
  c_calib_err: cover property (calib_active && calib_result_code != 8'h00);
  c_set_b: cover property (req.rd && page_id == PCCHR_PAGE_MASK_B);
endmodule // pcchr_regs_checker

bind pcchr_regs pcchr_regs_checker u_chk (.clk, .reset_n, .app_id, .page_id, .req, .rdata_r,
  .rvalid_r, .calib_result_code, .calib_active, .geom_r, .calib_failed_r, .hist_second_slot_r);
